/* File: wdt_regs.vh */
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define IDX_WDCTL          8'h8D
`define IDX_CKDIV          8'h8E
`define IDX_EXTIE          8'hE8
`define IDX_IRQ_STATUS     8'hF0
`define IDX_IRQ_MASK       8'hF1

// ==========================================================================
// Watchdog control and flags register fields.
`define WDCTL_EXPIRY_BIT   3
`define WDCTL_RSTFLAG_BIT  2
`define WDCTL_RSTEN_BIT    1
`define WDCTL_RESTART_BIT  0
`define WDCTL_RSTEN_RESET  1'b1

// ==========================================================================
// Clock divider and watchdog timeout register fields.
`define CKDIV_TSEL1_BIT    7
`define CKDIV_TSEL0_BIT    6
`define CKDIV_T2_BIT       5
`define CKDIV_T1_BIT       4
`define CKDIV_T0_BIT       3
`define CKDIV_TSEL2_BIT    2
`define CKDIV_RESET        8'hC7

// ==========================================================================
// Extended interrupt enable and interrupt status fields.
`define EXTIE_WDIRQ_BIT    0
`define IRQ_EXPIRY_BIT     0
`define IRQ_WDRESET_BIT    1

// ==========================================================================
// Watchdog timeout counts in CPU clock cycles, and prescale ratios.
`define WDT_TO_0           32'h0002_0000
`define WDT_TO_1           32'h0010_0000
`define WDT_TO_2           32'h0080_0000
`define WDT_TO_3           32'h0400_0000
`define WDT_TO_4           32'h0800_0000
`define WDT_TO_5           32'h1000_0000
`define WDT_TO_6           32'h2000_0000
`define WDT_TO_7           32'h4000_0000
`define PRESCALE_FAST      4'h4
`define PRESCALE_SLOW      4'hC

`endif

/* File: timer_prescaler.v */
`timescale 1ns/1ns
`default_nettype none
`include "wdt_regs.vh"

// ==========================================================================
// Divide-by-4 or divide-by-12 tick generator for one system timer.
module timer_prescaler (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       ce,
   input  wire       div4_sel,
   output reg        tick
);
   reg  [3:0] count_reg;
   wire [3:0] ratio;

   assign ratio = div4_sel ? `PRESCALE_FAST : `PRESCALE_SLOW;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 4'h0;
         tick      <= 1'b0;
      end else if (ce) begin
         if (count_reg >= ratio - 4'h1) begin
            count_reg <= 4'h0;
            tick      <= 1'b1;
         end else begin
            count_reg <= count_reg + 4'h1;
            tick      <= 1'b0;
         end
      end
   end
endmodule // timer_prescaler

`default_nettype wire

/* File: wdt_clk_ctrl.v */
// Function
// - Expiry flag sets regardless of interrupt enable.
// - Reset enables watchdog reset, longest timeout.
// - Unlocked restart write clears watchdog counter.
// - Restart bit is a strobe, reads zero.
// - Restart gated by timed-access unlock.
// - Locked restart write accepted, counter unchanged.
// - Watchdog interrupt enable in extended enable register.
// - Clock register resets to 0b11000111.
// - 30-bit counter, stops when clock halted.
// - Expiry raises interrupt or forces reset.
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_regs.vh"

module wdt_clk_ctrl #(
   parameter [31:0] TIMEOUT0 = `WDT_TO_0,
   parameter [31:0] TIMEOUT1 = `WDT_TO_1,
   parameter [31:0] TIMEOUT2 = `WDT_TO_2,
   parameter [31:0] TIMEOUT3 = `WDT_TO_3,
   parameter [31:0] TIMEOUT4 = `WDT_TO_4,
   parameter [31:0] TIMEOUT5 = `WDT_TO_5,
   parameter [31:0] TIMEOUT6 = `WDT_TO_6,
   parameter [31:0] TIMEOUT7 = `WDT_TO_7
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   input  wire        guarded_write_unlock,
   output reg         watchdog_irq,
   output reg         watchdog_system_reset,
   output wire        timer0_tick,
   output wire        timer1_tick,
   output wire        timer2_tick,
   output wire        irq
);
   // =======================================================================
   // Register state.
   reg  [29:0] wdt_count_reg;
   reg         watchdog_expiry_flag_reg;
   reg         watchdog_reset_flag_reg;
   reg         watchdog_reset_enable_reg;
   reg  [7:0]  clock_divider_watchdog_timeout_reg;
   reg         watchdog_irq_enable_reg;
   reg  [1:0]  irq_status_reg;
   reg  [1:0]  irq_mask_reg;

   reg  [31:0] timeout_sel_count;
   reg  [31:0] rd_next;
   reg         err_next;
   wire [2:0]  watchdog_timeout_select;
   wire [9:0]  word_index;
   wire        addr_aligned;
   wire        setup_phase;
   wire        wr_access;
   wire        hit_wdctl;
   wire        hit_ckdiv;
   wire        hit_extie;
   wire        hit_status;
   wire        hit_mask;
   wire        mapped;
   wire        restart_req;
   wire        expiry_event;
   wire        reset_event;

   // =======================================================================
   // Bus decode.
   assign word_index   = paddr[11:2];
   assign addr_aligned = (paddr[1:0] == 2'h0);
   assign hit_wdctl    = addr_aligned && (word_index == {2'h0, `IDX_WDCTL});
   assign hit_ckdiv    = addr_aligned && (word_index == {2'h0, `IDX_CKDIV});
   assign hit_extie    = addr_aligned && (word_index == {2'h0, `IDX_EXTIE});
   assign hit_status   = addr_aligned && (word_index == {2'h0, `IDX_IRQ_STATUS});
   assign hit_mask     = addr_aligned && (word_index == {2'h0, `IDX_IRQ_MASK});
   assign mapped       = hit_wdctl | hit_ckdiv | hit_extie | hit_status | hit_mask;
   assign setup_phase  = psel & ~penable & ce;
   assign wr_access    = psel & penable & pwrite & ce & mapped;
   assign pready       = ce;

   // =======================================================================
   // Timeout selection.
   assign watchdog_timeout_select = {
      clock_divider_watchdog_timeout_reg[`CKDIV_TSEL2_BIT],
      clock_divider_watchdog_timeout_reg[`CKDIV_TSEL1_BIT],
      clock_divider_watchdog_timeout_reg[`CKDIV_TSEL0_BIT]};

   always @* begin
      case (watchdog_timeout_select)
         3'h0:    timeout_sel_count = TIMEOUT0;
         3'h1:    timeout_sel_count = TIMEOUT1;
         3'h2:    timeout_sel_count = TIMEOUT2;
         3'h3:    timeout_sel_count = TIMEOUT3;
         3'h4:    timeout_sel_count = TIMEOUT4;
         3'h5:    timeout_sel_count = TIMEOUT5;
         3'h6:    timeout_sel_count = TIMEOUT6;
         default: timeout_sel_count = TIMEOUT7;
      endcase
   end

   // =======================================================================
   // Watchdog counter.
   // A locked write of the restart bit completes normally but does nothing.
   assign restart_req  = wr_access & hit_wdctl & pwdata[`WDCTL_RESTART_BIT]
                         & guarded_write_unlock;
   assign expiry_event = ce & ~restart_req
                         & ({2'h0, wdt_count_reg} >= timeout_sel_count - 32'h1);
   assign reset_event  = expiry_event & watchdog_reset_enable_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_count_reg <= 30'h0;
      end else if (ce) begin
         if (restart_req || expiry_event) begin
            wdt_count_reg <= 30'h0;
         end else begin
            wdt_count_reg <= wdt_count_reg + 30'h1;
         end
      end
   end

   // =======================================================================
   // Control and flag registers; a hardware set wins over a software clear.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_expiry_flag_reg           <= 1'b0;
         watchdog_reset_flag_reg            <= 1'b0;
         watchdog_reset_enable_reg          <= `WDCTL_RSTEN_RESET;
         clock_divider_watchdog_timeout_reg <= `CKDIV_RESET;
         watchdog_irq_enable_reg            <= 1'b0;
         irq_status_reg                     <= 2'h0;
         irq_mask_reg                       <= 2'h0;
         watchdog_irq                       <= 1'b0;
         watchdog_system_reset              <= 1'b0;
      end else if (ce) begin
         if (wr_access && hit_wdctl) begin
            watchdog_expiry_flag_reg  <= pwdata[`WDCTL_EXPIRY_BIT];
            watchdog_reset_flag_reg   <= pwdata[`WDCTL_RSTFLAG_BIT];
            watchdog_reset_enable_reg <= pwdata[`WDCTL_RSTEN_BIT];
         end
         if (expiry_event) begin
            watchdog_expiry_flag_reg <= 1'b1;
         end
         if (reset_event) begin
            watchdog_reset_flag_reg <= 1'b1;
         end
         if (wr_access && hit_ckdiv) begin
            clock_divider_watchdog_timeout_reg <= pwdata[7:0];
         end
         if (wr_access && hit_extie) begin
            watchdog_irq_enable_reg <= pwdata[`EXTIE_WDIRQ_BIT];
         end
         if (wr_access && hit_mask) begin
            irq_mask_reg <= pwdata[1:0];
         end
         irq_status_reg <= (irq_status_reg
                           & ~((wr_access && hit_status) ? pwdata[1:0] : 2'h0))
                           | {reset_event, expiry_event};
         watchdog_irq          <= watchdog_expiry_flag_reg & watchdog_irq_enable_reg;
         watchdog_system_reset <= reset_event;
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);

   // =======================================================================
   // Read data, loaded in the setup cycle and shown in the access cycle.
   always @* begin
      rd_next  = 32'h0;
      err_next = 1'b0;
      if (hit_wdctl) begin
         rd_next[`WDCTL_EXPIRY_BIT]  = watchdog_expiry_flag_reg;
         rd_next[`WDCTL_RSTFLAG_BIT] = watchdog_reset_flag_reg;
         rd_next[`WDCTL_RSTEN_BIT]   = watchdog_reset_enable_reg;
         rd_next[`WDCTL_RESTART_BIT] = 1'b0;
      end else if (hit_ckdiv) begin
         rd_next[7:0] = clock_divider_watchdog_timeout_reg;
      end else if (hit_extie) begin
         rd_next[`EXTIE_WDIRQ_BIT] = watchdog_irq_enable_reg;
      end else if (hit_status) begin
         rd_next[1:0] = irq_status_reg;
      end else if (hit_mask) begin
         rd_next[1:0] = irq_mask_reg;
      end else begin
         err_next = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata  <= pwrite ? 32'h0 : rd_next;
         pslverr <= err_next;
      end
   end

   // =======================================================================
   // Timer prescalers.
   timer_prescaler u_pre0 (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .div4_sel (clock_divider_watchdog_timeout_reg[`CKDIV_T0_BIT]),
      .tick     (timer0_tick)
   );

   timer_prescaler u_pre1 (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .div4_sel (clock_divider_watchdog_timeout_reg[`CKDIV_T1_BIT]),
      .tick     (timer1_tick)
   );

   timer_prescaler u_pre2 (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .div4_sel (clock_divider_watchdog_timeout_reg[`CKDIV_T2_BIT]),
      .tick     (timer2_tick)
   );
endmodule // wdt_clk_ctrl

`default_nettype wire

/* File: wdt_clk_ctrl_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Port checks of the watchdog and clock control block.
module wdt_clk_ctrl_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        watchdog_irq,
   input wire logic        watchdog_system_reset,
   input wire logic        timer0_tick,
   input wire logic        irq
);
   logic       en_m;
   logic       ie_m;
   logic [1:0] mask_m;
   logic [7:0] ck_m;
   wire        acc    = psel && penable && pready;
   wire        rd_acc = acc && !pwrite;
   wire        mapped = paddr inside {12'h234, 12'h238, 12'h3A0, 12'h3C0, 12'h3C4};
   // ==========================================================================
   // Shadow copies of written control bits.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_m   <= 1'h1;
         ie_m   <= 1'h0;
         mask_m <= 2'h0;
         ck_m   <= 8'hC7;
      end else if (acc && pwrite) begin
         case (paddr)
            12'h234: en_m   <= pwdata[1];
            12'h238: ck_m   <= pwdata[7:0];
            12'h3A0: ie_m   <= pwdata[0];
            12'h3C4: mask_m <= pwdata[1:0];
            default: ;
         endcase
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================================
   // Assertions.
   a_slverr_unmapped: assert property (acc |-> pslverr == !mapped)
      else $error("error response does not match address");
   a_upper_reads_zero: assert property (rd_acc |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_restart_reads_zero: assert property (rd_acc && paddr == 12'h234 |-> !prdata[0])
      else $error("restart bit reads one");
   a_reset_enable_read: assert property (rd_acc && paddr == 12'h234 |-> prdata[1] == en_m)
      else $error("reset enable read wrong");
   a_clock_reg_read: assert property (rd_acc && paddr == 12'h238 |-> prdata[7:0] == ck_m)
      else $error("clock register read wrong");
   a_irq_enable_read: assert property (rd_acc && paddr == 12'h3A0 |-> prdata[0] == ie_m)
      else $error("interrupt enable read wrong");
   a_wd_irq_enabled: assert property (watchdog_irq |-> $past(ie_m))
      else $error("watchdog interrupt without enable");
   a_irq_needs_mask: assert property (irq |-> mask_m != 2'h0)
      else $error("interrupt with all sources masked");
   a_sysrst_enabled: assert property (watchdog_system_reset |-> $past(en_m) || $past(en_m, 2))
      else $error("system reset while reset disabled");
   a_sysrst_pulse: assert property (disable iff (!presetn || !ce)
      watchdog_system_reset |=> !watchdog_system_reset)
      else $error("system reset longer than one cycle");
   a_tick_spacing: assert property (disable iff (!presetn || !ce)
      $rose(timer0_tick) |=> !timer0_tick [*3])
      else $error("timer ticks too close");
endmodule // wdt_clk_ctrl_props

bind wdt_clk_ctrl wdt_clk_ctrl_props wdt_clk_ctrl_props_inst (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .watchdog_irq(watchdog_irq), .watchdog_system_reset(watchdog_system_reset),
   .timer0_tick(timer0_tick), .irq(irq)
);
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wdt_regs.vh"
module tb;
   localparam int TO [8] = '{16, 24, 32, 40, 48, 56, 64, 72};
   logic        pclk, presetn, psel, penable, pwrite, unlock, slv, run;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd, ctl;
   wire         pready, pslverr, wd_irq, sys_rst, t0, t1, t2, irq;
   wire  [31:0] prdata;
   wire  [2:0]  ticks = {t2, t1, t0};
   int          num_errors, tests_run, cyc, n_rst, d, ref_c, g, n0;
   wdt_clk_ctrl #(.TIMEOUT0(TO[0]), .TIMEOUT1(TO[1]), .TIMEOUT2(TO[2]), .TIMEOUT3(TO[3]),
      .TIMEOUT4(TO[4]), .TIMEOUT5(TO[5]), .TIMEOUT6(TO[6]), .TIMEOUT7(TO[7]))
   wdt_clk_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(run), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .guarded_write_unlock(unlock),
      .watchdog_irq(wd_irq), .watchdog_system_reset(sys_rst), .timer0_tick(t0),
      .timer1_tick(t1), .timer2_tick(t2), .irq(irq));
   initial begin
      pclk = 1'h0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (sys_rst === 1'h1) begin
         n_rst <= n_rst + 1;
      end
   end
   // ==========================================================================
   // Checking and bus tasks.
   task automatic tally_and_finish;
      $display("errors %0d, checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic near(input int v, input int e);
      chk({31'h0, (v >= e - 1 && v <= e + 1)}, 32'h1);
   endtask
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         num_errors++;
         $display("unexpected at %0t: wait ran out", $time);
         tally_and_finish();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      guard(n, 50);
      rd = prdata;
      slv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic tick_gap(input int i);
      int n;
      n = 0;
      @(negedge pclk);
      while (ticks[i] !== 1'h1 && n < 40) begin
         @(negedge pclk);
         n++;
      end
      guard(n, 40);
      @(negedge pclk);
      g = 1;
      while (ticks[i] !== 1'h1 && g < 40) begin
         @(negedge pclk);
         g++;
      end
   endtask
   task automatic expiry(input int c, input logic mid, input logic mid_unl, input int hold);
      int n;
      apb(1'h1, `IDX_CKDIV, {24'h0, c[1], c[0], 3'h0, c[2], 2'h0});
      unlock <= 1'h1;
      apb(1'h1, `IDX_WDCTL, ctl);
      ref_c = cyc;
      unlock <= 1'h0;
      apb(1'h1, `IDX_IRQ_STATUS, 32'h3);
      if (hold > 0) begin
         run <= 1'h0;
         repeat (hold) @(posedge pclk);
         run <= 1'h1;
         ref_c = ref_c + hold;
      end
      if (mid) begin
         unlock <= mid_unl;
         apb(1'h1, `IDX_WDCTL, ctl);
         unlock <= 1'h0;
         if (mid_unl) begin
            ref_c = cyc;
         end
      end
      n = 0;
      while (irq !== 1'h1 && n < 200) begin
         @(negedge pclk);
         n++;
      end
      guard(n, 200);
      d = cyc - ref_c;
   endtask
   // ==========================================================================
   // Main sequence.
   localparam logic [7:0] RIDX [5] = '{`IDX_WDCTL, `IDX_CKDIV, `IDX_EXTIE, `IDX_IRQ_STATUS,
      `IDX_IRQ_MASK};
   localparam logic [31:0] RVAL [5] = '{32'h2, 32'hC7, 32'h0, 32'h0, 32'h0};
   initial begin
      {psel, penable, pwrite, unlock, paddr, pwdata, rd, slv} = '0;
      {num_errors, tests_run, cyc, n_rst} = '0;
      ctl = 32'h1;
      run = 1'h1;
      presetn = 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      for (int i = 0; i < 5; i++) begin
         apb(1'h0, RIDX[i], 32'h0);
         chk(rd, RVAL[i]);
      end
      apb(1'h0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, slv}, 32'h1);
      for (int s = 1; s >= 0; s--) begin
         apb(1'h1, `IDX_CKDIV, s ? 32'hFF : 32'hC7);
         for (int i = 0; i < 3; i++) begin
            tick_gap(i);
            chk(g, s ? 4 : 12);
         end
      end
      apb(1'h1, `IDX_IRQ_MASK, 32'h1);
      expiry(0, 1'h1, 1'h1, 0);
      near(d, TO[0]);
      expiry(0, 1'h1, 1'h0, 0);
      near(d, TO[0]);
      for (int k = 0; k < 8; k++) begin
         expiry(k, 1'h0, 1'h0, 0);
         near(d, TO[k]);
      end
      expiry(0, 1'h0, 1'h0, 10);
      near(d, TO[0]);
      apb(1'h0, `IDX_WDCTL, 32'h0);
      chk(rd & 32'hF, 32'h8);
      chk({31'h0, wd_irq}, 32'h0);
      apb(1'h1, `IDX_EXTIE, 32'h1);
      @(negedge pclk);
      chk({31'h0, wd_irq}, 32'h1);
      apb(1'h1, `IDX_WDCTL, 32'h0);
      @(negedge pclk);
      chk({31'h0, wd_irq}, 32'h0);
      ctl = 32'h3;
      n0 = n_rst;
      expiry(0, 1'h0, 1'h0, 0);
      repeat (3) @(negedge pclk);
      chk(n_rst - n0, 1);
      apb(1'h0, `IDX_WDCTL, 32'h0);
      chk(rd & 32'hE, 32'hE);
      apb(1'h1, `IDX_IRQ_MASK, 32'h0);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
